//--- rtl/cdsx_exec.sv
// Executor for the complement-file and decrement-skip-if-zero instructions.
// Assumes insn is stable from one quarter_phase_one through quarter_phase_four
// and that file_rdata is valid in the same clock as the file read request.
//
// What this block does
// [RQ1] Complement-file inverts the addressed register and updates the zero flag.
// [RQ2] Complement-file destination bit 0 writes accumulator, 1 writes file.
// [RQ3] One word, one cycle: decode, read, process, write phases.
// [RQ4] Decrement-skip subtracts one and steers by destination bit.
// [RQ5] Decrement-skip leaves all status flags unchanged; same four phases.
// [RQ6] Zero result discards next instruction, making it two cycles.
// [RQ7] Nonzero result lets the next instruction execute normally.
// [RQ8] The skip cycle performs no read, no processing, no write.
// [RQ9] Destination bit is instruction bit 7; address is bits 6 to 0.
`timescale 1ns/1ps
module cdsx_exec
  import cdsx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [DATA_W-1:0] file_rdata,
  output cdsx_file_t file_req,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic skip_active,
  output logic [1:0] quarter
);
  cdsx_phase_t phase;
  cdsx_dec_t dec;
  cdsx_dec_t next_dec;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;

  cdsx_phase u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase(phase)
  );

  always_comb begin
    next_dec.complement_file_op = insn[OPC_HI:OPC_LO] == OPC_COMPLEMENT; // RQ1
    next_dec.decrement_skip_zero_op = insn[OPC_HI:OPC_LO] == OPC_DEC_SKIP; // RQ4
    next_dec.dest_file = insn[DEST_BIT]; // RQ9
    next_dec.addr = insn[ADDR_W-1:0]; // RQ9
  end

  always_comb begin
    next_result = result;
    if (dec.complement_file_op) begin
      next_result = ~file_rdata; // RQ1
    end else if (dec.decrement_skip_zero_op) begin
      next_result = file_rdata - DATA_ONE; // RQ4
    end
  end

  // Decode in quarter_phase_one; a skip cycle decodes as nothing.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec <= '0;
    end else if (phase == CDSX_Q1) begin
      if (skip_active) begin
        dec <= '0; // RQ8
      end else begin
        dec <= next_dec; // RQ3
      end
    end
  end

  // Read request in quarter_phase_two, write in quarter_phase_four.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      file_req <= '0;
    end else begin
      file_req.rd <= phase == CDSX_Q2 &&
        (dec.complement_file_op || dec.decrement_skip_zero_op); // RQ3
      file_req.wr <= phase == CDSX_Q4 && dec.dest_file &&
        (dec.complement_file_op || dec.decrement_skip_zero_op); // RQ2
      file_req.addr <= dec.addr;
      file_req.wdata <= result; // RQ4
    end
  end

  // Process in quarter_phase_three.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= DATA_ZERO;
    end else if (phase == CDSX_Q3) begin
      result <= next_result; // RQ3
    end
  end

  // Accumulator and zero flag written in quarter_phase_four.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= DATA_ZERO;
    end else if (phase == CDSX_Q4 && !dec.dest_file &&
      (dec.complement_file_op || dec.decrement_skip_zero_op)) begin
      acc <= result; // RQ2
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_flag <= 1'b0;
    end else if (phase == CDSX_Q4 && dec.complement_file_op) begin
      zero_flag <= result == DATA_ZERO; // RQ1 RQ5
    end
  end

  // The following instruction cycle becomes a no-operation on a zero decrement-skip result.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_active <= 1'b0;
    end else if (phase == CDSX_Q4) begin
      skip_active <= dec.decrement_skip_zero_op &&
        result == DATA_ZERO; // RQ6 RQ7
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quarter <= 2'h0;
    end else begin
      quarter <= phase;
    end
  end

  skip_nowrite_a: assert property (@(posedge clk) disable iff (sys_rst)
    skip_active |=> !file_req.wr && !file_req.rd) // RQ8
    else $error("skip cycle touched the file");
  skip_taken_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && dec.decrement_skip_zero_op && result == DATA_ZERO
    |=> skip_active) // RQ6
    else $error("zero result did not skip");
  no_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && dec.decrement_skip_zero_op && result != DATA_ZERO
    |=> !skip_active) // RQ7
    else $error("nonzero result skipped");
  skip_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(skip_active) |-> skip_active [*4] ##1 !skip_active) // RQ6
    else $error("skip not one cycle long");
  flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !dec.complement_file_op |=> $stable(zero_flag)) // RQ5
    else $error("zero flag changed wrongly");
  comp_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && dec.complement_file_op
    |=> zero_flag == ($past(result) == DATA_ZERO)) // RQ1
    else $error("zero flag wrong");
  acc_dest_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && !dec.dest_file &&
    (dec.complement_file_op || dec.decrement_skip_zero_op)
    |=> acc == $past(result)) // RQ2 RQ4
    else $error("accumulator not written");
  wr_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
    file_req.wr |-> $past(phase) == CDSX_Q4 && $past(dec.dest_file)) // RQ3
    else $error("file write outside last phase");
  rd_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
    file_req.rd |-> $past(phase) == CDSX_Q2) // RQ3
    else $error("file read outside second phase");

  // Quarter phases and the decode of each instruction word.
  phase_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q1 |=> phase == CDSX_Q2 ##1 phase == CDSX_Q3
      ##1 phase == CDSX_Q4 ##1 phase == CDSX_Q1) // RQ3
    else $error("quarter phases out of order");
  quarter_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
    quarter == $past(phase)) // RQ3
    else $error("quarter output does not follow the phase");
  decode_fields_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q1 && !skip_active
    |=> dec.addr == $past(insn[ADDR_W-1:0]) &&
      dec.dest_file == $past(insn[DEST_BIT])) // RQ9
    else $error("address or destination decoded wrongly");
  refuse_op_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q1 && insn[OPC_HI:OPC_LO] != OPC_COMPLEMENT &&
    insn[OPC_HI:OPC_LO] != OPC_DEC_SKIP
    |=> !dec.complement_file_op && !dec.decrement_skip_zero_op) // RQ3
    else $error("unknown opcode decoded as an instruction");
  skip_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q1 && skip_active
    |=> !dec.complement_file_op && !dec.decrement_skip_zero_op) // RQ8
    else $error("skip cycle decoded an instruction");

  // Read, process and write of the addressed file register.
  rd_issue_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q2 &&
    (dec.complement_file_op || dec.decrement_skip_zero_op)
    |=> file_req.rd) // RQ3
    else $error("read not issued in the second phase");
  rd_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    file_req.rd |-> file_req.addr == $past(dec.addr)) // RQ9
    else $error("read sent to the wrong address");
  comp_value_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q3 && dec.complement_file_op
    |=> result == ~$past(file_rdata)) // RQ1
    else $error("complement result wrong");
  dec_value_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q3 && dec.decrement_skip_zero_op
    |=> result == $past(file_rdata) - DATA_ONE) // RQ4
    else $error("decrement result wrong");
  wr_issue_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && dec.dest_file &&
    (dec.complement_file_op || dec.decrement_skip_zero_op)
    |=> file_req.wr) // RQ2 RQ4
    else $error("file write not issued");
  wr_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    file_req.wr |-> file_req.wdata == $past(result) &&
      file_req.addr == $past(dec.addr)) // RQ2
    else $error("file write carries wrong data or address");
  wr_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    file_req.wr |=> !file_req.wr) // RQ3
    else $error("file write longer than one clock");

  // Registers that a given cycle must leave alone.
  acc_file_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase == CDSX_Q4 && dec.dest_file |=> $stable(acc)) // RQ2
    else $error("accumulator written for a file destination");
  acc_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
    skip_active |=> $stable(acc)) // RQ8
    else $error("accumulator changed during a skip cycle");
  dec_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    dec.decrement_skip_zero_op |=> $stable(zero_flag)) // RQ5
    else $error("decrement changed the zero flag");

  skip_c: cover property (@(posedge clk) $rose(skip_active));
  comp_c: cover property (@(posedge clk) dec.complement_file_op &&
    phase == CDSX_Q4);
  wr_c: cover property (@(posedge clk) file_req.wr);
  keep_c: cover property (@(posedge clk) phase == CDSX_Q4 &&
    dec.decrement_skip_zero_op && result != DATA_ZERO);
  acc_c: cover property (@(posedge clk) phase == CDSX_Q4 &&
    !dec.dest_file && dec.decrement_skip_zero_op);
endmodule

//--- rtl/cdsx_pkg.sv
// Constants and carrier types for the complement and decrement-skip executor.
// Assumes a 14-bit instruction word and an 8-bit file register bank outside.
package cdsx_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef enum logic [1:0] {
    CDSX_Q1, CDSX_Q2, CDSX_Q3, CDSX_Q4
  } cdsx_phase_t;

  typedef struct packed {
    logic complement_file_op;
    logic decrement_skip_zero_op;
    logic dest_file;
    logic [6:0] addr;
  } cdsx_dec_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cdsx_file_t;
endpackage

//--- rtl/cdsx_phase.sv
// Quarter-phase generator: one instruction cycle is four core clocks.
// Assumes the core clock runs continuously after reset.
`timescale 1ns/1ps
module cdsx_phase
  import cdsx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  output cdsx_phase_t phase
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= CDSX_Q1;
    end else begin
      case (phase)
        CDSX_Q1: phase <= CDSX_Q2;
        CDSX_Q2: phase <= CDSX_Q3;
        CDSX_Q3: phase <= CDSX_Q4;
        default: phase <= CDSX_Q1;
      endcase
    end
  end
endmodule

//--- tb/cdsx_exec_tb.sv
// Self-checking bench for the complement and decrement-skip executor.
// Assumes the bench stands in for the file bank and the program sequencer.
`timescale 1ns/1ps
module cdsx_exec_tb;
  import cdsx_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic [INSN_W-1:0] insn = '0;
  logic [DATA_W-1:0] file_rdata = '0;
  cdsx_file_t file_req;
  logic [DATA_W-1:0] acc;
  logic zero_flag;
  logic skip_active;
  logic [1:0] quarter;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'h5d68e5a0;
  logic [7:0] mem [128];
  logic [7:0] acc_m = '0;
  logic [7:0] pwd = '0;
  logic [6:0] pa = '0;
  logic z_m = 0;
  logic pwr = 0;
  logic pskip = 0;
  logic [5:0] ops [4] = '{OPC_COMPLEMENT, OPC_DEC_SKIP, OPC_DEC_SKIP, 6'h0a};

  cdsx_exec cdsx_exec_i (.clk(clk), .sys_rst(sys_rst), .insn(insn),
    .file_rdata(file_rdata), .file_req(file_req), .acc(acc),
    .zero_flag(zero_flag), .skip_active(skip_active), .quarter(quarter));

  initial forever #5 clk = ~clk;

  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [16:0] g, input logic [16:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Results of an instruction show after its quarter_phase_four edge.
  task automatic check_prev;
    cmp(17'(quarter), 17'(PHASE_LAST));
    cmp(17'(file_req.wr), 17'(pwr));
    if (pwr) cmp({file_req.addr, file_req.wdata}, {pa, pwd});
    cmp(17'(acc), 17'(acc_m));
    cmp(17'(zero_flag), 17'(z_m));
    cmp(17'(skip_active), 17'(pskip));
  endtask

  task automatic step(input logic [5:0] op, input logic d,
                      input logic [6:0] a);
    logic [7:0] r;
    logic ok;
    ok = (op == OPC_COMPLEMENT) || (op == OPC_DEC_SKIP);
    if (pskip) begin
      insn = 14'($random(seed));
      pskip = 0;
      pwr = 0;
      repeat (3) begin
        @(negedge clk);
        cmp({skip_active, file_req.rd, file_req.wr}, 17'h4);
      end
      @(negedge clk);
      check_prev;
    end
    insn = {op, d, a};
    r = (op == OPC_COMPLEMENT) ? ~mem[a] : mem[a] - 8'h01;
    @(negedge clk);
    @(negedge clk);
    if (ok) cmp({file_req.rd, file_req.addr}, {1'b1, a});
    else cmp(17'(file_req.rd), 17'h0);
    file_rdata = mem[a];
    @(negedge clk);
    file_rdata = ~file_rdata;
    @(negedge clk);
    pwr = ok & d;
    if (ok) begin
      pa = a;
      pwd = r;
      if (!d) acc_m = r;
      else mem[a] = r;
      if (op == OPC_COMPLEMENT) z_m = (r == 8'h00);
      else pskip = (r == 8'h00);
    end
    check_prev;
  endtask

  initial begin
    #20000;
    num_errors++;
    complete_run;
  end

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
    repeat (20) @(negedge clk);
    sys_rst = 0;
    mem[5] = 8'h01;
    step(OPC_DEC_SKIP, 1'b1, 7'h05);
    step(OPC_DEC_SKIP, 1'b0, 7'h05);
    mem[9] = 8'hff;
    step(OPC_COMPLEMENT, 1'b0, 7'h09);
    step(OPC_COMPLEMENT, 1'b1, 7'h7f);
    mem[3] = 8'h01;
    step(OPC_DEC_SKIP, 1'b0, 7'h03);
    step(OPC_DEC_SKIP, 1'b1, 7'h03);
    repeat (60) step(ops[2'($random(seed))], 1'($random(seed)),
                     7'($random(seed)));
    step(6'h00, 1'b0, 7'h00);
    complete_run;
  end
endmodule
